// ==== include/dmacr_pkg.sv ====
// package: dma channel control constants, states and carriers
package dmacr_pkg;
    localparam int NCH = 4;
    localparam logic [3:0][7:0] CH_PAGE = {8'h21, 8'h20, 8'h01, 8'h00};
    localparam logic [15:0] COMMON_ADDR = 16'h4000;
    localparam logic [7:0] PG_PERF = 8'h90;
    localparam logic [7:0] PG_GC0 = 8'h91;
    localparam logic [7:0] PG_GC1 = 8'h92;
    localparam logic [7:0] PG_PWR = 8'h94;
    localparam logic [3:0] BLK_MAC0 = 4'hB;
    localparam logic [3:0] BLK_MAC1 = 4'hC;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_NEXT = 8'h08;
    localparam logic [7:0] OFF_SWPTR = 8'h0C;
    localparam logic [7:0] OFF_TALLY = 8'h1C;
    localparam int B_IE = 0;
    localparam int B_IA = 1;
    localparam int B_DC = 2;
    localparam int B_AE = 3;
    localparam int B_FE = 4;
    localparam int B_SA = 5;
    localparam int B_EN = 8;
    localparam int B_RUN = 10;
    localparam int B_WAIT = 11;
    localparam int B_RREQ = 14;
    localparam int B_RST = 15;
    localparam int PTR_LSB = 5;
    localparam int CNT_LSB = 2;
    localparam int GIE_BIT = 0;
    localparam int IRQ_BIT = 1;
    localparam int PEND_BIT = 2;
    localparam int H2C_STAT_LSB = 16;
    localparam int C2S_STAT_LSB = 24;
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_S = 1;
    localparam int SAMPLE_CYC = CLK_HZ * SAMPLE_S;
    localparam int SEC_W = 27;
    localparam int FIFO_W = 32;
    localparam int FIFO_D = 32;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_WAIT = 3'b100
    } dmacr_state_t;

    typedef struct packed {
        logic rst;
        logic rreq;
        logic en;
        logic sa;
        logic fe;
        logic ae;
        logic dc;
        logic ia;
        logic ie;
    } dmacr_ctrl_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } dmacr_reg_req_t;

    typedef struct packed {
        logic [5:0] sel;
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } dmacr_usr_req_t;

    typedef struct packed {
        logic done;
        logic ioc;
        logic fetch_err;
        logic [31:0] next_addr;
    } dmacr_desc_rsp_t;
endpackage

// ==== verilog/dmacr_fifo.sv ====
// module: streaming fifo with registered read data
`timescale 1ns/1ps
module dmacr_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input wire logic clk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic clr_in, // flush contents
    input wire logic in_valid_in, // write valid
    input wire logic [W-1:0] in_data_in, // write data
    output logic in_ready_out, // room available
    output logic out_valid_out, // head valid
    output logic [W-1:0] out_data_out, // head data
    input wire logic out_ready_in // head taken
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic [W-1:0] dout_ff, nxt_dout;
    logic ov_ff, nxt_ov, push, load;

    assign in_ready_out = !clr_in && cnt_ff != (AW+1)'(D);
    assign out_valid_out = ov_ff;
    assign out_data_out = dout_ff;

    always_comb begin
        push = in_valid_in && in_ready_out;
        load = cnt_ff != '0 && (!ov_ff || out_ready_in);
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = load ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(load);
        nxt_dout = load ? mem[rp_ff] : dout_ff;
        nxt_ov = load || (ov_ff && !out_ready_in);
        if (clr_in) begin
            nxt_wp = '0;
            nxt_rp = '0;
            nxt_cnt = '0;
            nxt_ov = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_ff] <= in_data_in;
        end
        if (rst_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            dout_ff <= '0;
            ov_ff <= 1'b0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            dout_ff <= nxt_dout;
            ov_ff <= nxt_ov;
        end
    end
endmodule // dmacr_fifo

// ==== verilog/dmacr_top.sv ====
// module: dma channel control and status registers, four engines
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
module dmacr_top #(
    parameter int SAMPLE_CYCLES = dmacr_pkg::SAMPLE_CYC // cycles per sample
) (
    input wire logic ref_clk_in, // 100 MHz clock
    input wire logic rst_in, // sync reset, high
    input wire dmacr_pkg::dmacr_reg_req_t reg_req_in, // register access
    output logic rd_valid_out, // read answer strobe
    output logic [31:0] rd_data_out, // read answer data
    output dmacr_pkg::dmacr_usr_req_t usr_req_out, // user region access
    input wire logic [31:0] usr_rdata_in, // user region read data
    input wire dmacr_pkg::dmacr_desc_rsp_t [3:0] desc_rsp_in, // descriptor results
    output logic [3:0] fetch_req_out, // engine wants descriptor
    output logic [3:0][31:0] fetch_addr_out, // descriptor address
    input wire logic [3:1] xfer_beat_in, // 4-byte beat, channels 1..3
    output logic [3:0] rst_req_out, // abort and prepare request
    input wire logic [3:0] rst_ack_in, // user acknowledge
    output logic [3:0] user_rst_out, // reset to user logic
    output logic irq_out, // gated interrupt
    input wire logic h2c_valid_in, // channel 0 stream valid
    input wire logic [31:0] h2c_data_in, // channel 0 stream data
    output logic h2c_ready_out, // channel 0 stream ready
    output logic h2c_valid_out, // user stream valid
    output logic [31:0] h2c_data_out, // user stream data
    input wire logic h2c_ready_in // user stream ready
);
    import dmacr_pkg::*;

    dmacr_ctrl_t [3:0] ctrl_ff, nxt_ctrl;
    dmacr_state_t [3:0] st_ff, nxt_st;
    logic [3:0][31-PTR_LSB:0] chain_ff, nxt_chain, swp_ff, nxt_swp;
    logic [3:0] ch_hit, wr_ctl, wr_nxt, wr_sw, live, pend;
    logic [3:0] ev_dc, ev_ae, ev_fe, ev_sa, ev_ia;
    logic [SEC_W-1:0] sec_ff, nxt_sec;
    logic tick;
    logic [3:0] beat;
    logic [3:0][31-CNT_LSB:0] acc_ff, nxt_acc, cnt_ff, nxt_cnt;
    logic [3:0][1:0] samp_ff, nxt_samp;
    logic gie_ff, nxt_gie, irq_ff, nxt_irq;
    logic rdv_ff, nxt_rdv;
    logic [31:0] rdd_ff, nxt_rdd, loc_data;
    logic [5:0] usr_sel;
    logic com_hit;
    dmacr_usr_req_t usr_ff, nxt_usr;

    // ---------------------------------------------------------------
    // stream buffer, channel 0
    // ---------------------------------------------------------------
    dmacr_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) i_dmacr_fifo (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .clr_in(ctrl_ff[0].rst),
        .in_valid_in(h2c_valid_in),
        .in_data_in(h2c_data_in),
        .in_ready_out(h2c_ready_out),
        .out_valid_out(h2c_valid_out),
        .out_data_out(h2c_data_out),
        .out_ready_in(h2c_ready_in)
    );

    // ---------------------------------------------------------------
    // engine control per channel
    // ---------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_st = st_ff;
        nxt_chain = chain_ff;
        nxt_swp = swp_ff;
        ch_hit = '0;
        wr_ctl = '0;
        wr_nxt = '0;
        wr_sw = '0;
        live = '0;
        ev_dc = '0;
        ev_ae = '0;
        ev_fe = '0;
        ev_sa = '0;
        ev_ia = '0;
        for (int c = 0; c < NCH; c++) begin
            ch_hit[c] = reg_req_in.valid && reg_req_in.addr[15:8] == CH_PAGE[c];
            wr_ctl[c] = ch_hit[c] && reg_req_in.write && reg_req_in.addr[7:0] == OFF_CTRL;
            wr_nxt[c] = ch_hit[c] && reg_req_in.write && reg_req_in.addr[7:0] == OFF_NEXT;
            wr_sw[c] = ch_hit[c] && reg_req_in.write && reg_req_in.addr[7:0] == OFF_SWPTR;
            live[c] = st_ff[c] == ST_RUN && !ctrl_ff[c].rst;
            ev_ae[c] = live[c] && desc_rsp_in[c].done && !desc_rsp_in[c].fetch_err
                && desc_rsp_in[c].next_addr[PTR_LSB-1:0] != '0;
            ev_fe[c] = live[c] && desc_rsp_in[c].done && desc_rsp_in[c].fetch_err;
            ev_dc[c] = live[c] && desc_rsp_in[c].done && !desc_rsp_in[c].fetch_err
                && !ev_ae[c] && desc_rsp_in[c].ioc;
            ev_sa[c] = wr_ctl[c] && !reg_req_in.wdata[B_EN] && st_ff[c] == ST_RUN;
            ev_ia[c] = ev_dc[c] | ev_ae[c] | ev_fe[c];
            if (wr_ctl[c]) begin
                nxt_ctrl[c].ie = reg_req_in.wdata[B_IE];
                nxt_ctrl[c].en = reg_req_in.wdata[B_EN];
                nxt_ctrl[c].rreq = reg_req_in.wdata[B_RREQ];
                nxt_ctrl[c].rst = reg_req_in.wdata[B_RST];
            end
            if (ctrl_ff[c].rreq && rst_ack_in[c]) begin
                nxt_ctrl[c].rreq = 1'b0;
            end
            nxt_ctrl[c].ia = ev_ia[c] | (ctrl_ff[c].ia & ~(wr_ctl[c] & reg_req_in.wdata[B_IA]));
            nxt_ctrl[c].dc = ev_dc[c] | (ctrl_ff[c].dc & ~(wr_ctl[c] & reg_req_in.wdata[B_DC]));
            nxt_ctrl[c].ae = ev_ae[c] | (ctrl_ff[c].ae & ~(wr_ctl[c] & reg_req_in.wdata[B_AE]));
            nxt_ctrl[c].fe = ev_fe[c] | (ctrl_ff[c].fe & ~(wr_ctl[c] & reg_req_in.wdata[B_FE]));
            nxt_ctrl[c].sa = ev_sa[c] | (ctrl_ff[c].sa & ~(wr_ctl[c] & reg_req_in.wdata[B_SA]));
            if (wr_nxt[c] && !ctrl_ff[c].en) begin
                nxt_chain[c] = reg_req_in.wdata[31:PTR_LSB];
            end
            if (wr_sw[c]) begin
                nxt_swp[c] = reg_req_in.wdata[31:PTR_LSB];
            end
            if (live[c] && desc_rsp_in[c].done && !ev_fe[c] && !ev_ae[c]) begin
                nxt_chain[c] = desc_rsp_in[c].next_addr[31:PTR_LSB];
            end
            if (ev_ae[c] || ev_fe[c]) begin
                nxt_ctrl[c].en = 1'b0;
            end
            if (ctrl_ff[c].rst) begin
                nxt_ctrl[c].en = 1'b0;
            end
            case (st_ff[c])
                ST_IDLE: begin
                    if (nxt_ctrl[c].en) begin
                        nxt_st[c] = (nxt_chain[c] == nxt_swp[c]) ? ST_WAIT : ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!nxt_ctrl[c].en) begin
                        nxt_st[c] = ST_IDLE;
                    end else if (nxt_chain[c] == nxt_swp[c]) begin
                        nxt_st[c] = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!nxt_ctrl[c].en) begin
                        nxt_st[c] = ST_IDLE;
                    end else if (nxt_chain[c] != nxt_swp[c]) begin
                        nxt_st[c] = ST_RUN;
                    end
                end
                default: begin
                    nxt_st[c] = ST_IDLE;
                end
            endcase
            if (ctrl_ff[c].rst) begin
                nxt_st[c] = ST_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ctrl_ff <= '0;
            st_ff <= '{default: ST_IDLE};
            chain_ff <= '0;
            swp_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            st_ff <= nxt_st;
            chain_ff <= nxt_chain;
            swp_ff <= nxt_swp;
        end
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            fetch_req_out[c] = live[c];
            fetch_addr_out[c] = {chain_ff[c], {PTR_LSB{1'b0}}};
            rst_req_out[c] = ctrl_ff[c].rreq;
            user_rst_out[c] = ctrl_ff[c].rst;
            pend[c] = ctrl_ff[c].ie & ctrl_ff[c].ia;
        end
    end

    // ---------------------------------------------------------------
    // one-second byte tally
    // ---------------------------------------------------------------
    always_comb begin
        tick = sec_ff == SEC_W'(SAMPLE_CYCLES - 1);
        nxt_sec = tick ? '0 : sec_ff + 1'b1;
        beat = {xfer_beat_in, h2c_valid_out & h2c_ready_in};
        nxt_cnt = cnt_ff;
        for (int c = 0; c < NCH; c++) begin
            if (tick) begin
                nxt_cnt[c] = acc_ff[c] + (32-CNT_LSB)'(beat[c]);
                nxt_acc[c] = '0;
            end else begin
                nxt_acc[c] = acc_ff[c] + (32-CNT_LSB)'(beat[c]);
            end
            nxt_samp[c] = samp_ff[c] + 2'(tick);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sec_ff <= '0;
            acc_ff <= '0;
            cnt_ff <= '0;
            samp_ff <= '0;
        end else begin
            sec_ff <= nxt_sec;
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            samp_ff <= nxt_samp;
        end
    end

    // ---------------------------------------------------------------
    // read path, common register, user routing
    // ---------------------------------------------------------------
    always_comb begin
        usr_sel = {reg_req_in.addr[15:12] == BLK_MAC1, reg_req_in.addr[15:12] == BLK_MAC0,
            reg_req_in.addr[15:8] == PG_PWR, reg_req_in.addr[15:8] == PG_GC1,
            reg_req_in.addr[15:8] == PG_GC0, reg_req_in.addr[15:8] == PG_PERF};
        com_hit = reg_req_in.valid && reg_req_in.addr == COMMON_ADDR;
        loc_data = '0;
        for (int c = 0; c < NCH; c++) begin
            if (ch_hit[c]) begin
                case (reg_req_in.addr[7:0])
                    OFF_CTRL: begin
                        loc_data[B_IE] = ctrl_ff[c].ie;
                        loc_data[B_IA] = ctrl_ff[c].ia;
                        loc_data[B_DC] = ctrl_ff[c].dc;
                        loc_data[B_AE] = ctrl_ff[c].ae;
                        loc_data[B_FE] = ctrl_ff[c].fe;
                        loc_data[B_SA] = ctrl_ff[c].sa;
                        loc_data[B_EN] = ctrl_ff[c].en;
                        loc_data[B_RUN] = st_ff[c] == ST_RUN;
                        loc_data[B_WAIT] = st_ff[c] == ST_WAIT;
                        loc_data[B_RREQ] = ctrl_ff[c].rreq;
                        loc_data[B_RST] = ctrl_ff[c].rst;
                    end
                    OFF_NEXT: begin
                        loc_data = {chain_ff[c], {PTR_LSB{1'b0}}};
                    end
                    OFF_SWPTR: begin
                        loc_data = {swp_ff[c], {PTR_LSB{1'b0}}};
                    end
                    OFF_TALLY: begin
                        loc_data = {cnt_ff[c], samp_ff[c]};
                    end
                    default: begin
                        loc_data = '0;
                    end
                endcase
            end
        end
        if (com_hit) begin
            loc_data[GIE_BIT] = gie_ff;
            loc_data[IRQ_BIT] = irq_ff;
            loc_data[PEND_BIT] = |pend;
            loc_data[H2C_STAT_LSB +: 2] = pend[1:0];
            loc_data[C2S_STAT_LSB +: 2] = pend[3:2];
        end
        nxt_gie = (com_hit && reg_req_in.write) ? reg_req_in.wdata[GIE_BIT] : gie_ff;
        nxt_irq = gie_ff && |pend;
        nxt_usr.sel = usr_sel;
        nxt_usr.valid = reg_req_in.valid && |usr_sel;
        nxt_usr.write = reg_req_in.write;
        nxt_usr.addr = reg_req_in.addr;
        nxt_usr.wdata = reg_req_in.wdata;
        nxt_rdv = 1'b0;
        nxt_rdd = rdd_ff;
        if (usr_ff.valid && !usr_ff.write) begin
            nxt_rdv = 1'b1;
            nxt_rdd = usr_rdata_in;
        end else if (reg_req_in.valid && !reg_req_in.write && !(|usr_sel)) begin
            nxt_rdv = 1'b1;
            nxt_rdd = loc_data;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            gie_ff <= 1'b0;
            irq_ff <= 1'b0;
            usr_ff <= '0;
            rdv_ff <= 1'b0;
            rdd_ff <= '0;
        end else begin
            gie_ff <= nxt_gie;
            irq_ff <= nxt_irq;
            usr_ff <= nxt_usr;
            rdv_ff <= nxt_rdv;
            rdd_ff <= nxt_rdd;
        end
    end

    assign usr_req_out = usr_ff;
    assign rd_valid_out = rdv_ff;
    assign rd_data_out = rdd_ff;
    assign irq_out = irq_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_rd_next3;
        reg_req_in.valid && !reg_req_in.write && reg_req_in.addr == {CH_PAGE[3], OFF_NEXT};
    endsequence
    sequence s_run_equal;
        ctrl_ff[0].en && !ctrl_ff[0].rst && st_ff[0] != ST_IDLE
            && chain_ff[0] == swp_ff[0];
    endsequence

    chk_chan_decode: assert property (s_rd_next3 |=> rd_valid_out
        && rd_data_out[31:PTR_LSB] == $past(chain_ff[3]))
        else $error("channel 3 pointer read wrong");
    chk_user_route: assert property (reg_req_in.valid && reg_req_in.addr[15:8] == PG_GC0
        |=> usr_req_out.valid && usr_req_out.sel == 6'h02)
        else $error("user group not routed");
    chk_ia_sticky: assert property (ev_ia[0] |=> ctrl_ff[0].ia)
        else $error("interrupt active not set");
    chk_desc_done: assert property (ev_dc[0] |=> ctrl_ff[0].dc && ctrl_ff[0].ia)
        else $error("descriptor complete not flagged");
    chk_align_abort: assert property (ev_ae[2] |=> ctrl_ff[2].ae && st_ff[2] == ST_IDLE
        ##1 st_ff[2] == ST_IDLE)
        else $error("unaligned descriptor not aborted");
    chk_sw_abort: assert property (ev_sa[2] |=> ctrl_ff[2].sa && !live[2])
        else $error("software abort not flagged");
    chk_req_ack: assert property (ctrl_ff[3].rreq && rst_ack_in[3] |=> !rst_req_out[3])
        else $error("reset request not cleared");
    chk_eng_reset: assert property (ctrl_ff[3].rst |-> user_rst_out[3] ##1 !live[3])
        else $error("reset bit did not stop engine");
    chk_ptr_lock: assert property (ctrl_ff[0].en && !desc_rsp_in[0].done
        |=> $stable(chain_ff[0]))
        else $error("next pointer moved while enabled");
    chk_global_gate: assert property (!gie_ff ##1 !gie_ff |-> !irq_out)
        else $error("interrupt passed global gate");
    chk_wait_entry: assert property (s_run_equal |-> st_ff[0] == ST_WAIT)
        else $error("equal pointers did not wait");
    chk_tally_samp: assert property (tick |=> samp_ff[1] == $past(samp_ff[1]) + 2'h1)
        else $error("sample counter did not step");
endmodule // dmacr_top

// ==== verif/dmacr_user_model.sv ====
// user side model: register answers, reset acknowledge, stream sink
`timescale 1ns/1ps
module dmacr_user_model
    import dmacr_pkg::*;
(
    input wire logic clk_in, // clock
    input wire dmacr_pkg::dmacr_usr_req_t req_in, // forwarded access
    output logic [31:0] rdata_out, // read answer
    input wire logic [3:0] rreq_in, // reset requests
    output logic [3:0] ack_out, // acknowledges
    input wire logic stall_in, // sink stall
    input wire logic valid_in, // stream valid
    input wire logic [31:0] data_in, // stream data
    output logic ready_out // stream ready
);
    logic [31:0] rx_q[$];
    initial ack_out = 4'h0;
    always @(posedge clk_in) ack_out <= rreq_in & ~ack_out;
    // idle bus shows inverted pattern
    assign rdata_out = req_in.valid ? {16'h5A5A, req_in.addr} : {16'hA5A5, ~req_in.addr};
    assign ready_out = ~stall_in;
    always @(posedge clk_in) begin
        if (valid_in && ready_out) begin
            rx_q.push_back(data_in);
        end
    end
endmodule // dmacr_user_model

// ==== verif/tb_dmacr_top.sv ====
// self-checking bench for the channel control registers
`timescale 1ns/1ps
module tb_dmacr_top;
    import dmacr_pkg::*;
    localparam int SC = 16;
    dmacr_reg_req_t req;
    dmacr_usr_req_t ureq;
    dmacr_desc_rsp_t [3:0] rsp;
    logic ref_clk_in, rst_in, rd_valid_out, irq_out, stall, hv_in, h_rdy, hv_out, u_rdy;
    logic [31:0] rd_data_out, urd, hd_in, hd_out, got, t1;
    logic [3:0][31:0] fadr;
    logic [3:0] freq, rreq, ack, urst;
    logic [3:1] beat;
    logic [5:0] sel_seen;
    logic [31:0] sent[$];
    logic [15:0] ua[6] = '{16'h9000, 16'h9104, 16'h9208, 16'h94FC, 16'hB010, 16'hCFF0};
    logic [31:0] ek[3] = '{32'h0A, 32'h12, 32'h20};
    int err_total = 0, checks = 0, cyc = 0, tk, n, seed;
    dmacr_top #(.SAMPLE_CYCLES(SC)) i_dmacr_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .reg_req_in(req), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
        .usr_req_out(ureq), .usr_rdata_in(urd), .desc_rsp_in(rsp), .fetch_req_out(freq),
        .fetch_addr_out(fadr), .xfer_beat_in(beat), .rst_req_out(rreq), .rst_ack_in(ack),
        .user_rst_out(urst), .irq_out(irq_out), .h2c_valid_in(hv_in), .h2c_data_in(hd_in),
        .h2c_ready_out(h_rdy), .h2c_valid_out(hv_out), .h2c_data_out(hd_out),
        .h2c_ready_in(u_rdy));
    dmacr_user_model i_dmacr_user_model (.clk_in(ref_clk_in), .req_in(ureq), .rdata_out(urd),
        .rreq_in(rreq), .ack_out(ack), .stall_in(stall), .valid_in(hv_out), .data_in(hd_out),
        .ready_out(u_rdy));
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (ureq.valid) sel_seen <= ureq.sel;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        checks++;
        if (act !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task automatic cy(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        cy(1);
        req = '{1'b1, 1'b1, a, d};
        cy(1);
        req.valid = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        cy(1);
        req = '{1'b1, 1'b0, a, 32'h0};
        cy(1);
        req.valid = 1'b0;
        tk = cyc;
        for (n = 0; n < 4 && rd_valid_out !== 1'b1; n++) cy(1);
        got = (n < 4) ? rd_data_out : 32'hDEAD_BEEF;
    endtask
    task automatic done(input int c, input logic fe, input logic [31:0] na);
        cy(1);
        rsp[c] = '{1'b1, 1'b1, fe, na};
        cy(1);
        rsp[c].done = 1'b0;
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        seed = 32'hAB7AA536;
        rst_in = 1'b1;
        req = '0;
        rsp = '0;
        beat = 3'h0;
        stall = 1'b1;
        hv_in = 1'b0;
        hd_in = 32'h0;
        cy(10);
        rst_in = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            rd({CH_PAGE[c], OFF_CTRL});
            chk("ctrl_rst", 32'h0, got);
            t1 = $random(seed);
            wr({CH_PAGE[c], OFF_SWPTR}, t1);
            wr({CH_PAGE[c], OFF_NEXT}, ~t1);
            rd({CH_PAGE[c], OFF_SWPTR});
            chk("swptr", t1 & 32'hFFFF_FFE0, got);
            rd({CH_PAGE[c], OFF_NEXT});
            chk("next", ~t1 & 32'hFFFF_FFE0, got);
        end
        rd(16'h3000);
        chk("hole", 32'h0, got);
        for (int i = 0; i < 6; i++) begin
            rd(ua[i]);
            chk("usr_rd", {16'h5A5A, ua[i]}, got);
            chk("usr_sel", 32'(6'h01 << i), 32'(sel_seen));
        end
        wr(16'h0008, 32'h100);
        wr(16'h000C, 32'h200);
        wr(COMMON_ADDR, 32'h1);
        wr(16'h0004, 32'h101);
        rd(16'h0004);
        chk("run", 32'h501, got);
        chk("fetch", 32'h100, fadr[0]);
        chk("fetch_req", 32'h1, 32'(freq));
        wr(16'h0008, 32'h300);
        rd(16'h0008);
        chk("next_lock", 32'h100, got);
        done(0, 1'b0, 32'h200);
        rd(16'h0004);
        chk("wait", 32'h907, got);
        chk("fetch_idle", 32'h0, 32'(freq));
        chk("irq", 32'h1, 32'(irq_out));
        rd(COMMON_ADDR);
        chk("common", 32'h10007, got);
        wr(16'h0004, 32'h103);
        rd(16'h0004);
        chk("w1c", 32'h905, got);
        chk("irq_off", 32'h0, 32'(irq_out));
        for (int k = 0; k < 3; k++) begin
            wr(16'h2008, 32'h40);
            wr(16'h200C, 32'h80);
            wr(16'h2004, 32'h13E);
            if (k < 2) done(2, k == 1, (k == 0) ? 32'h61 : 32'h80);
            else wr(16'h2004, 32'h0);
            rd(16'h2004);
            chk("err_flag", ek[k], got);
        end
        wr(16'h2104, 32'h4000);
        for (n = 0; n < 6 && rreq[3] !== 1'b1; n++) cy(1);
        chk("rreq", 32'h1, 32'(rreq[3]));
        cy(2);
        rd(16'h2104);
        chk("rreq_clr", 32'h0, got);
        wr(16'h2104, 32'h8100);
        rd(16'h2104);
        chk("rst_bit", 32'h8000, got);
        chk("usr_rst", 32'h8, 32'(urst));
        wr(16'h2104, 32'h0);
        hv_in = 1'b1;
        for (int i = 0; i < 40; i++) begin
            hd_in = $random(seed);
            if (h_rdy === 1'b1) sent.push_back(hd_in);
            cy(1);
        end
        hv_in = 1'b0;
        chk("fill", 32'd33, sent.size());
        repeat (150) begin
            cy(1);
            stall = 1'($random(seed));
        end
        stall = 1'b0;
        cy(10);
        chk("drain", sent.size(), i_dmacr_user_model.rx_q.size());
        foreach (sent[i]) chk("word", sent[i], i_dmacr_user_model.rx_q[i]);
        beat = 3'h7;
        cy(40);
        rd(16'h011C);
        t1 = got;
        n = tk;
        while (cyc < n + 30) cy(1);
        rd(16'h011C);
        chk("tally", {30'(SC), 2'(t1[1:0] + 2'd2)}, got);
        conclude();
    end
endmodule // tb_dmacr_top
